// file: src/prio_bank_pkg.sv
`default_nettype none
package prio_bank_pkg;
    // register word indices; byte address is four times the index
    localparam logic [3:0] IDX_EXT1 = 4'h5;
    localparam logic [3:0] IDX_TMR4 = 4'h6;
    localparam logic [3:0] IDX_SER2 = 4'h7;
    localparam logic [3:0] IDX_SPI2 = 4'h8;
    localparam logic [3:0] IDX_CAP = 4'h9;
    localparam logic [3:0] IDX_CMP5 = 4'ha;
    localparam logic [3:0] IDX_PAR = 4'hb;
    localparam logic [3:0] IDX_TW2 = 4'hc;
    localparam int NUM_SRC = 17;
    localparam int LVL_W = 3;
    localparam int REG_W = 16;
    // field low bit positions within a 16-bit register
    localparam int POS_HI = 12;
    localparam int POS_MH = 8;
    localparam int POS_ML = 4;
    localparam int POS_LO = 0;
    // level codes
    localparam logic [2:0] LVL_RESET = 3'h4;
    localparam logic [2:0] LVL_OFF = 3'h0;
    localparam logic [2:0] LVL_MIN = 3'h1;
    localparam logic [2:0] LVL_MAX = 3'h7;
    // source table: register index and field position per source
    localparam logic [3:0] SRC_IDX [NUM_SRC] = '{
        IDX_EXT1, IDX_TMR4, IDX_TMR4, IDX_TMR4, IDX_SER2, IDX_SER2, IDX_SER2, IDX_SER2,
        IDX_SPI2, IDX_SPI2, IDX_CAP, IDX_CAP, IDX_CAP, IDX_CMP5, IDX_PAR, IDX_TW2, IDX_TW2};
    localparam int SRC_POS [NUM_SRC] = '{
        POS_LO, POS_HI, POS_MH, POS_ML, POS_HI, POS_MH, POS_ML, POS_LO,
        POS_ML, POS_LO, POS_HI, POS_MH, POS_ML, POS_ML, POS_ML, POS_MH, POS_ML};
    // per-source level bundle
    typedef struct packed {
        logic [2:0] ext_irq1_level;
        logic [2:0] timer_four_level;
        logic [2:0] compare_four_level;
        logic [2:0] compare_three_level;
        logic [2:0] serial2_tx_level;
        logic [2:0] serial2_rx_level;
        logic [2:0] ext_irq2_level;
        logic [2:0] timer_five_level;
        logic [2:0] spi_two_event_level;
        logic [2:0] spi_two_fault_level;
        logic [2:0] capture_five_level;
        logic [2:0] capture_four_level;
        logic [2:0] capture_three_level;
        logic [2:0] compare_five_level;
        logic [2:0] parallel_port_level;
        logic [2:0] twowire2_master_level;
        logic [2:0] twowire2_slave_level;
    } level_bank_t;
endpackage
`default_nettype wire

// file: src/interrupt_priority_regs_b.sv
// Implementation choices: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - each source owns a 3-bit level field and code 7 is the top user level.
// - code 1 is the lowest active level of a source.
// - code 0 disables a source, flagged on source_enabled low.
// - every unimplemented bit, spacer bits included, reads as zero.
// - reset loads every field with binary 100.
// - every field bit is read/write and reads back the last written value.
// - external interrupt 1 sits at bits 2-0 of register five, bits 15-3 unused.
// - register six holds timer 4, compare 4 and compare 3 at 14-12, 10-8, 6-4.
// - register seven holds serial 2 tx, rx, ext 2 and timer 5 at 14-12, 10-8, 6-4, 2-0.
// - register eight holds spi 2 event at 6-4 and spi 2 fault at 2-0.
// - register nine holds capture 5, 4 and 3 at 14-12, 10-8, 6-4.
// - register ten holds compare 5 at 6-4 only.
// - register eleven holds the parallel port level at 6-4 only.
// - register twelve holds two-wire 2 master at 10-8 and slave at 6-4.
module interrupt_priority_regs_b (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    // level outputs to arbitration
    output prio_bank_pkg::level_bank_t levels,
    output logic [16:0] source_enabled
);
    import prio_bank_pkg::*;

    // address map: one 16-bit register per 32-bit word, word index in
    // address bits 5:2, registers five to twelve at byte 0x14 to 0x30
    // the upper half of every read word is zero and writes there are
    // dropped, since no field lives in it
    // each source keeps one 3-bit code and the code is the level itself:
    // 0 switches the source off, 1 is the lowest and 7 the highest level
    // the spacer bit above every field has no storage, so it reads zero
    // whatever software wrote into it
    // limitation: byte lanes 2 and 3 are ignored, and a word index outside
    // five to twelve is refused with an error rather than silently acked
    // trade-off: every answer costs one registered cycle, which keeps all
    // bus outputs straight from flip-flops at the price of a wait state

    // level code storage, one entry per source in source-table order
    logic [2:0] field [NUM_SRC];

    // bus decode terms
    logic [3:0] word_idx;
    logic req;
    logic hit;
    logic wr_req;
    logic rd_req;
    logic [1:0] lane_wr;

    // register words as software sees them, spacer bits included
    logic [15:0] word_ext1;
    logic [15:0] word_tmr4;
    logic [15:0] word_ser2;
    logic [15:0] word_spi2;
    logic [15:0] word_cap;
    logic [15:0] word_cmp5;
    logic [15:0] word_par;
    logic [15:0] word_tw2;
    logic [15:0] rd_word;

    // word index sits above the two byte-offset bits
    assign word_idx = wb_adr_i[5:2];

    // a new request only once the previous answer has dropped, so a
    // master that keeps stb up one cycle longer is not served twice
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;

    // mapped words are the unbroken run from register five to twelve
    assign hit = (word_idx >= IDX_EXT1) && (word_idx <= IDX_TW2);

    // accepted requests split by direction; only mapped words count
    assign wr_req = req && hit && wb_we_i;
    assign rd_req = req && hit && !wb_we_i;

    // byte lane write enables; lanes 2 and 3 carry no fields
    assign lane_wr[0] = wr_req && wb_sel_i[0];
    assign lane_wr[1] = wr_req && wb_sel_i[1];

    // one level field per source, placed by the source table
    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g++) begin : g_src
            localparam int P = SRC_POS[g];
            logic lane_ok;
            logic field_wr;

            // field sits in byte lane 1 when above bit 7, else lane 0
            assign lane_ok = (P >= 8) ? lane_wr[1] : lane_wr[0];

            // only the three field bits are taken from the write data;
            // a lane-masked write keeps the field as it was
            assign field_wr = lane_ok && (word_idx == SRC_IDX[g]);

            // reset lands on code 4, the middle of the user range, so no
            // source is disabled before software has touched the bank
            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    field[g] <= LVL_RESET;
                end else if (field_wr) begin
                    field[g] <= wb_dat_i[P +: LVL_W];
                end
            end
        end
    endgenerate

    // read words are built field by field from the package positions;
    // every bit not named here stays zero
    // register five: external interrupt 1 only
    always_comb begin
        word_ext1 = 16'h0000;
        // external interrupt 1
        word_ext1[POS_LO +: LVL_W] = field[0];
    end

    // register six: timer 4, compare 4, compare 3; low nibble unused
    always_comb begin
        word_tmr4 = 16'h0000;
        // timer 4
        word_tmr4[POS_HI +: LVL_W] = field[1];
        // compare 4
        word_tmr4[POS_MH +: LVL_W] = field[2];
        // compare 3
        word_tmr4[POS_ML +: LVL_W] = field[3];
    end

    // register seven: all four field slots in use
    always_comb begin
        word_ser2 = 16'h0000;
        // serial 2 transmit
        word_ser2[POS_HI +: LVL_W] = field[4];
        // serial 2 receive
        word_ser2[POS_MH +: LVL_W] = field[5];
        // external interrupt 2
        word_ser2[POS_ML +: LVL_W] = field[6];
        // timer 5
        word_ser2[POS_LO +: LVL_W] = field[7];
    end

    // register eight: spi 2 event and fault in the low byte
    always_comb begin
        word_spi2 = 16'h0000;
        // spi 2 event
        word_spi2[POS_ML +: LVL_W] = field[8];
        // spi 2 fault
        word_spi2[POS_LO +: LVL_W] = field[9];
    end

    // register nine: capture 5, 4 and 3; low nibble unused
    always_comb begin
        word_cap = 16'h0000;
        // capture 5
        word_cap[POS_HI +: LVL_W] = field[10];
        // capture 4
        word_cap[POS_MH +: LVL_W] = field[11];
        // capture 3
        word_cap[POS_ML +: LVL_W] = field[12];
    end

    // register ten: compare 5 only
    always_comb begin
        word_cmp5 = 16'h0000;
        // compare 5
        word_cmp5[POS_ML +: LVL_W] = field[13];
    end

    // register eleven: parallel port only
    always_comb begin
        word_par = 16'h0000;
        // parallel port
        word_par[POS_ML +: LVL_W] = field[14];
    end

    // register twelve: two-wire 2 master and slave
    always_comb begin
        word_tw2 = 16'h0000;
        // two-wire 2 master
        word_tw2[POS_MH +: LVL_W] = field[15];
        // two-wire 2 slave
        word_tw2[POS_ML +: LVL_W] = field[16];
    end

    // read select by word index; an unmapped index reads zero and the
    // answer block flags it with an error anyway
    always_comb begin
        case (word_idx)
            IDX_EXT1: rd_word = word_ext1;
            IDX_TMR4: rd_word = word_tmr4;
            IDX_SER2: rd_word = word_ser2;
            IDX_SPI2: rd_word = word_spi2;
            IDX_CAP: rd_word = word_cap;
            IDX_CMP5: rd_word = word_cmp5;
            IDX_PAR: rd_word = word_par;
            IDX_TW2: rd_word = word_tw2;
            default: rd_word = 16'h0000;
        endcase
    end

    // acknowledge one cycle after a mapped request is taken; the req
    // term already holds off while the previous answer stands, so ack
    // is a single-cycle pulse even when stb lingers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req && hit;
        end
    end

    // error one cycle after a request to a word outside the bank; such
    // a request changes nothing, so software can probe the map safely
    // without disturbing any level
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_err_o <= 1'b0;
        end else begin
            wb_err_o <= req && !hit;
        end
    end

    // read data stands only with its ack and is zero otherwise, so a
    // stale word never lingers on the bus after the answer; writes
    // answer with zero data as well
    // the upper half is always zero because no register is wider
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_dat_o <= rd_req ? {16'h0000, rd_word} : 32'h0000_0000;
        end
    end

    // registered copies toward arbitration; the level code itself is the
    // ranking, so the arbiter compares raw codes and a higher code wins
    // the copy lags the field by one cycle, which keeps the outputs
    // straight from flip-flops
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            // register five
            levels.ext_irq1_level <= LVL_RESET;

            // register six
            levels.timer_four_level <= LVL_RESET;
            levels.compare_four_level <= LVL_RESET;
            levels.compare_three_level <= LVL_RESET;

            // register seven
            levels.serial2_tx_level <= LVL_RESET;
            levels.serial2_rx_level <= LVL_RESET;
            levels.ext_irq2_level <= LVL_RESET;
            levels.timer_five_level <= LVL_RESET;

            // register eight
            levels.spi_two_event_level <= LVL_RESET;
            levels.spi_two_fault_level <= LVL_RESET;

            // register nine
            levels.capture_five_level <= LVL_RESET;
            levels.capture_four_level <= LVL_RESET;
            levels.capture_three_level <= LVL_RESET;

            // register ten
            levels.compare_five_level <= LVL_RESET;

            // register eleven
            levels.parallel_port_level <= LVL_RESET;

            // register twelve
            levels.twowire2_master_level <= LVL_RESET;
            levels.twowire2_slave_level <= LVL_RESET;
        end else begin
            // external interrupt 1
            levels.ext_irq1_level <= field[0];

            // timer 4
            levels.timer_four_level <= field[1];
            // compare 4
            levels.compare_four_level <= field[2];
            // compare 3
            levels.compare_three_level <= field[3];

            // serial 2 transmit
            levels.serial2_tx_level <= field[4];
            // serial 2 receive
            levels.serial2_rx_level <= field[5];
            // external interrupt 2
            levels.ext_irq2_level <= field[6];
            // timer 5
            levels.timer_five_level <= field[7];

            // spi 2 event
            levels.spi_two_event_level <= field[8];
            // spi 2 fault
            levels.spi_two_fault_level <= field[9];

            // capture 5
            levels.capture_five_level <= field[10];
            // capture 4
            levels.capture_four_level <= field[11];
            // capture 3
            levels.capture_three_level <= field[12];

            // compare 5
            levels.compare_five_level <= field[13];

            // parallel port
            levels.parallel_port_level <= field[14];

            // two-wire 2 master
            levels.twowire2_master_level <= field[15];
            // two-wire 2 slave
            levels.twowire2_slave_level <= field[16];
        end
    end

    // enable flags, highest bit for the first source; code 0 clears the
    // flag so the arbiter can skip a disabled source without decoding it
    // reset sets every flag because every field resets to a live code
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            source_enabled <= '1;
        end else begin
            for (int i = 0; i < NUM_SRC; i++) begin
                source_enabled[NUM_SRC-1-i] <= (field[i] != LVL_OFF);
            end
        end
    end
endmodule
`default_nettype wire

// file: verif/prio_bank_props.sv
`timescale 1ns/1ps
`default_nettype none
module prio_bank_props (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // bus strobes
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    // bus address, lanes and data
    input wire logic [5:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    // level outputs
    input wire prio_bank_pkg::level_bank_t levels,
    input wire logic [16:0] source_enabled
);
    import prio_bank_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // a request not yet answered, a write to the ext 1 field, a read answer
    sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o; endsequence
    sequence s_wr5; s_req ##0 wb_we_i && wb_adr_i[5:2] == IDX_EXT1 && wb_sel_i[0]; endsequence
    sequence s_rd5; wb_ack_o && !wb_we_i && wb_adr_i[5:2] == IDX_EXT1; endsequence
    a_ack_answer: assert property (s_req |=> wb_ack_o ^ wb_err_o)
        else $error("request not answered in one cycle");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
    a_upper_zero: assert property (wb_dat_o[31:15] == 17'h0) else $error("upper bits");
    a_spacer_zero: assert property (!wb_dat_o[11] && !wb_dat_o[7] && !wb_dat_o[3])
        else $error("spacer bit set");
    a_reg5_unused: assert property (s_rd5 |-> wb_dat_o[15:3] == 13'h0)
        else $error("ext 1 word unused bits");
    a_reg5_level: assert property (s_rd5 |-> wb_dat_o[2:0] == levels.ext_irq1_level)
        else $error("ext 1 read differs from level");
    a_write_lands: assert property (s_wr5 |=> wb_ack_o ##1
        levels.ext_irq1_level == $past(wb_dat_i[2:0], 2)) else $error("write not applied");
    a_enable_code: assert property (source_enabled[16] == (levels.ext_irq1_level != LVL_OFF)
        && source_enabled[0] == (levels.twowire2_slave_level != LVL_OFF)) else $error("enable");
endmodule
bind interrupt_priority_regs_b prio_bank_props i_prio_bank_props (.*);
`default_nettype wire

// file: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import prio_bank_pkg::*;
    logic sys_clk = 0, rst_n = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o, wb_err_o, e;
    logic [5:0] wb_adr_i = 6'h0;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
    level_bank_t levels;
    logic [16:0] source_enabled;
    int mismatches = 0, total_checks = 0;
    // implemented field bits of the words at indices 5 to 12
    logic [15:0] rows [8] = '{16'h0007, 16'h7770, 16'h7777, 16'h0077,
        16'h7770, 16'h0070, 16'h0070, 16'h0770};
    interrupt_priority_regs_b i_interrupt_priority_regs_b (.*);
    always #5 sys_clk = ~sys_clk;
    task automatic chk(input string nm, input logic [50:0] s, input logic [50:0] x);
        total_checks++;
        if (s !== x) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, x, s);
        end
    endtask
    // one classic cycle; only the watchdog ends a wait with no answer
    task automatic xfer(input logic w, input logic [3:0] a, input logic [15:0] d);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
        wb_adr_i <= {a, 2'h0};
        wb_dat_i <= {16'h0, d};
        do @(posedge sys_clk); while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
        q = wb_dat_o;
        e = wb_err_o;
        {wb_cyc_i, wb_stb_i} <= 2'b0;
        @(posedge sys_clk);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // watchdog sized far above the few hundred cycles the tests need
    initial begin
        #100000;
        mismatches++;
        report_and_stop();
    end
    initial begin
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        chk("reset levels", levels, {17{LVL_RESET}});
        // per word: reset value, all ones, then the lowest active code
        foreach (rows[i]) begin
            xfer(1'b0, 4'(i + 5), 16'h0);
            chk("reset word", q, rows[i] & 16'h4444);
            xfer(1'b1, 4'(i + 5), 16'hffff);
            xfer(1'b0, 4'(i + 5), 16'h0);
            chk("ones word", q, rows[i]);
            xfer(1'b1, 4'(i + 5), 16'h1111);
            xfer(1'b0, 4'(i + 5), 16'h0);
            chk("low word", q, rows[i] & 16'h1111);
        end
        chk("low levels", levels, {17{LVL_MIN}});
        foreach (rows[i]) xfer(1'b1, 4'(i + 5), 16'h0);
        chk("all disabled", source_enabled, 17'h0);
        // codes 7, 5, 3, 3 in one word pin the tx, rx and timer 5 fields to their own sources
        xfer(1'b1, IDX_SER2, 16'hf5b3);
        xfer(1'b0, IDX_SER2, 16'h0);
        chk("mixed word", q, 32'h0000_7533);
        chk("tx level", levels.serial2_tx_level, 3'h7);
        chk("rx level", levels.serial2_rx_level, 3'h5);
        chk("timer 5 level", levels.timer_five_level, 3'h3);
        chk("mixed enables", source_enabled, 17'h01e00);
        // unmapped word must refuse and leave the bank alone
        xfer(1'b1, 4'hd, 16'hffff);
        chk("unmapped err", e, 1'b1);
        xfer(1'b0, 4'h5, 16'h0);
        chk("bank untouched", q, 32'h0);
        // second reset in mid-run
        rst_n <= 1'b0;
        @(posedge sys_clk);
        chk("rereset levels", levels, {17{LVL_RESET}});
        rst_n <= 1'b1;
        // lane 0 only: the upper lane fields keep their reset code
        wb_sel_i <= 4'h1;
        xfer(1'b1, IDX_TMR4, 16'h0);
        wb_sel_i <= 4'hf;
        xfer(1'b0, IDX_TMR4, 16'h0);
        chk("lane write", q, 32'h0000_4400);
        chk("lane enables", source_enabled, 17'h1dfff);
        report_and_stop();
    end
endmodule
`default_nettype wire
